/* tcc_pkg.sv */
// Constants, types and register layout of the timer capture control block
// Behaviour
// R01: Writing one to the force-high bit drives the timer output high.
// R02: Writing one to the force-low bit drives the timer output low; the code drives it high when force-high is also written one.
// R03: Both output override bits read zero; writing zero leaves the output alone.
// R04: Tie bit feeds capture input two from capture input one's pin.
// R05: Second edge field: 00 falling, 01 rising, 10 or 11 both edges.
// R06: First edge field: 00 falling, 01 rising, 10 or 11 both edges.
// R07: Second timer interrupt enable gates the second timer interrupt request.
// R08: First timer interrupt enable gates the first timer interrupt request.
// R09: Writing one to the second clear bit clears the second timer counter.
// R10: Writing one to the first clear bit clears the first timer counter.
// R11: Both clear bits are strobes: read zero, writing zero does nothing.
// R12: Unused control bits and reserved configuration top bit read zero, ignore writes.
// R13: Each capture one event sets a sticky flag until software clears it.
package tcc_pkg;

    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned IRQ_W  = 4;

    // Register word offsets on the plain register port
    localparam logic [ADDR_W-1:0] ADDR_CAP_CFG   = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_PAIR_CTRL = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT  = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK  = 4'h3;

    // Capture configuration fields
    localparam int unsigned CFG_FORCE_HIGH = 6;
    localparam int unsigned CFG_FORCE_LOW  = 5;
    localparam int unsigned CFG_TIE        = 4;
    localparam int unsigned CFG_SEL2_HI    = 3;
    localparam int unsigned CFG_SEL2_LO    = 2;
    localparam int unsigned CFG_SEL1_HI    = 1;
    localparam int unsigned CFG_SEL1_LO    = 0;
    localparam logic [DATA_W-1:0] CFG_STORED_MASK = 8'h1f;

    // Pair control fields
    localparam int unsigned CTRL_T2_IE  = 5;
    localparam int unsigned CTRL_T1_IE  = 4;
    localparam int unsigned CTRL_T2_CLR = 1;
    localparam int unsigned CTRL_T1_CLR = 0;
    localparam logic [DATA_W-1:0] CTRL_STORED_MASK = 8'h30;

    // Interrupt status and mask layout
    localparam int unsigned ST_CAP1 = 0;
    localparam int unsigned ST_CAP2 = 1;
    localparam int unsigned ST_T1   = 2;
    localparam int unsigned ST_T2   = 3;

    localparam logic [DATA_W-1:0] CFG_RESET  = 8'h00;
    localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
    localparam logic [IRQ_W-1:0]  IRQ_RESET  = 4'h0;
    localparam logic [DATA_W-1:0] RD_IDLE    = 8'h00;
    localparam logic              PIN_RESET  = 1'b0;

    typedef enum logic [1:0] {
        EDGE_FALL     = 2'b00,
        EDGE_RISE     = 2'b01,
        EDGE_BOTH     = 2'b10,
        EDGE_BOTH_ALT = 2'b11
    } tcc_edge_sel_t;

endpackage : tcc_pkg

/* tcc_edge_det.sv */
// Edge detector for one synchronous capture input
`timescale 1ns/100ps
module tcc_edge_det (
    input  wire logic                   clk,
    input  wire logic                   srst,
    input  wire logic                   ce,
    input  wire logic                   sample,
    input  wire tcc_pkg::tcc_edge_sel_t edge_sel,
    output logic                        hit
);
    import tcc_pkg::*;

    logic prev_q;
    logic prev_d;

    always_comb begin
        prev_d = prev_q;
        if (ce) begin
            prev_d = sample;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
        end
    end

    always_comb begin
        unique case (edge_sel)
            EDGE_FALL:     hit = prev_q & ~sample;
            EDGE_RISE:     hit = ~prev_q & sample;
            EDGE_BOTH,
            EDGE_BOTH_ALT: hit = prev_q ^ sample;
        endcase
    end

endmodule : tcc_edge_det

/* tcc_top.sv */
// Timer capture configuration and pair control with register port and interrupts
`timescale 1ns/100ps
module tcc_top (
    input  wire logic                       clk,
    input  wire logic                       srst,
    input  wire logic                       ce,
    input  wire logic [tcc_pkg::ADDR_W-1:0] bus_addr,
    input  wire logic [tcc_pkg::DATA_W-1:0] bus_wdata,
    input  wire logic                       bus_wr,
    input  wire logic                       bus_rd,
    output logic      [tcc_pkg::DATA_W-1:0] bus_rdata,
    input  wire logic                       capture_input_one,
    input  wire logic                       capture_input_two,
    input  wire logic                       first_timer_event,
    input  wire logic                       second_timer_event,
    output logic                            timer_output_pin,
    output logic                            first_timer_clear,
    output logic                            second_timer_clear,
    output logic                            capture_one_event,
    output logic                            capture_two_event,
    output logic                            capture_one_flag,
    output logic                            capture_two_pin_free,
    output logic                            first_timer_irq,
    output logic                            second_timer_irq,
    output logic                            irq
);
    import tcc_pkg::*;

    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] target);
        reg_hit = (addr == target);
    endfunction : reg_hit

    // Write strobes per register
    logic wr_cfg;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_mask;
    logic rd_any;

    assign wr_cfg  = ce & bus_wr & reg_hit(bus_addr, ADDR_CAP_CFG);
    assign wr_ctrl = ce & bus_wr & reg_hit(bus_addr, ADDR_PAIR_CTRL);
    assign wr_stat = ce & bus_wr & reg_hit(bus_addr, ADDR_IRQ_STAT);
    assign wr_mask = ce & bus_wr & reg_hit(bus_addr, ADDR_IRQ_MASK);
    assign rd_any  = ce & bus_rd;

    // Configuration state
    logic [DATA_W-1:0] cfg_q;
    logic [DATA_W-1:0] cfg_d;
    logic [DATA_W-1:0] ctrl_q;
    logic [DATA_W-1:0] ctrl_d;
    logic              pin_q;
    logic              pin_d;

    always_comb begin
        cfg_d  = cfg_q;
        ctrl_d = ctrl_q;
        pin_d  = pin_q;
        if (wr_cfg) begin
            // Only tie and edge fields are stored; override bits never latch
            cfg_d = bus_wdata & CFG_STORED_MASK; // [R03] [R12]
            if (bus_wdata[CFG_FORCE_LOW]) begin
                pin_d = 1'b0; // [R02]
            end
            // Force-high is checked last so it wins when both are written
            if (bus_wdata[CFG_FORCE_HIGH]) begin
                pin_d = 1'b1; // [R01]
            end
        end
        if (wr_ctrl) begin
            ctrl_d = bus_wdata & CTRL_STORED_MASK; // [R11] [R12]
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cfg_q  <= CFG_RESET;
            ctrl_q <= CTRL_RESET;
            pin_q  <= PIN_RESET;
        end else begin
            cfg_q  <= cfg_d;
            ctrl_q <= ctrl_d;
            pin_q  <= pin_d;
        end
    end

    logic          tie_q;
    tcc_edge_sel_t sel1;
    tcc_edge_sel_t sel2;

    assign tie_q = cfg_q[CFG_TIE];
    assign sel1  = tcc_edge_sel_t'(cfg_q[CFG_SEL1_HI:CFG_SEL1_LO]);
    assign sel2  = tcc_edge_sel_t'(cfg_q[CFG_SEL2_HI:CFG_SEL2_LO]);

    // Clear strobes: one cycle per write of a one, nothing on a zero
    logic clr1_q;
    logic clr1_d;
    logic clr2_q;
    logic clr2_d;

    always_comb begin
        clr1_d = clr1_q;
        clr2_d = clr2_q;
        if (ce) begin
            clr1_d = wr_ctrl & bus_wdata[CTRL_T1_CLR]; // [R10] [R11]
            clr2_d = wr_ctrl & bus_wdata[CTRL_T2_CLR]; // [R09] [R11]
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            clr1_q <= 1'b0;
            clr2_q <= 1'b0;
        end else begin
            clr1_q <= clr1_d;
            clr2_q <= clr2_d;
        end
    end

    // Capture path; changing the tie bit can itself look like an edge on input two
    logic cap2_src;
    logic hit1;
    logic hit2;
    logic evt1_q;
    logic evt1_d;
    logic evt2_q;
    logic evt2_d;

    assign cap2_src = tie_q ? capture_input_one : capture_input_two; // [R04]

    tcc_edge_det u_edge_one (
        .clk      (clk),
        .srst     (srst),
        .ce       (ce),
        .sample   (capture_input_one),
        .edge_sel (sel1),
        .hit      (hit1)
    ); // [R06]

    tcc_edge_det u_edge_two (
        .clk      (clk),
        .srst     (srst),
        .ce       (ce),
        .sample   (cap2_src),
        .edge_sel (sel2),
        .hit      (hit2)
    ); // [R05]

    always_comb begin
        evt1_d = evt1_q;
        evt2_d = evt2_q;
        if (ce) begin
            evt1_d = hit1;
            evt2_d = hit2;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            evt1_q <= 1'b0;
            evt2_q <= 1'b0;
        end else begin
            evt1_q <= evt1_d;
            evt2_q <= evt2_d;
        end
    end

    // Interrupt status, mask and request outputs
    logic [IRQ_W-1:0] stat_q;
    logic [IRQ_W-1:0] stat_d;
    logic [IRQ_W-1:0] mask_q;
    logic [IRQ_W-1:0] mask_d;
    logic [IRQ_W-1:0] set_vec;
    logic             irq_q;
    logic             irq_d;
    logic             t1_irq_q;
    logic             t1_irq_d;
    logic             t2_irq_q;
    logic             t2_irq_d;

    always_comb begin
        set_vec          = '0;
        set_vec[ST_CAP1] = evt1_q;
        set_vec[ST_CAP2] = evt2_q;
        set_vec[ST_T1]   = first_timer_event;
        set_vec[ST_T2]   = second_timer_event;
        stat_d   = stat_q;
        mask_d   = mask_q;
        irq_d    = irq_q;
        t1_irq_d = t1_irq_q;
        t2_irq_d = t2_irq_q;
        if (ce) begin
            if (wr_stat) begin
                stat_d = stat_q & ~bus_wdata[IRQ_W-1:0];
            end
            // A new event in the clearing cycle survives the clear
            stat_d = stat_d | set_vec; // [R13]
            if (wr_mask) begin
                mask_d = bus_wdata[IRQ_W-1:0];
            end
            irq_d    = |(stat_q & mask_q);
            t1_irq_d = stat_q[ST_T1] & ctrl_q[CTRL_T1_IE]; // [R08]
            t2_irq_d = stat_q[ST_T2] & ctrl_q[CTRL_T2_IE]; // [R07]
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            stat_q   <= IRQ_RESET;
            mask_q   <= IRQ_RESET;
            irq_q    <= 1'b0;
            t1_irq_q <= 1'b0;
            t2_irq_q <= 1'b0;
        end else begin
            stat_q   <= stat_d;
            mask_q   <= mask_d;
            irq_q    <= irq_d;
            t1_irq_q <= t1_irq_d;
            t2_irq_q <= t2_irq_d;
        end
    end

    // Read data stand for exactly one cycle after the strobe
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic              pin_free_q;
    logic              pin_free_d;

    always_comb begin
        rdata_d    = rdata_q;
        pin_free_d = pin_free_q;
        if (ce) begin
            rdata_d    = RD_IDLE;
            pin_free_d = tie_q; // [R04]
            if (rd_any) begin
                unique case (bus_addr)
                    ADDR_CAP_CFG:   rdata_d = cfg_q & CFG_STORED_MASK; // [R03] [R12]
                    ADDR_PAIR_CTRL: rdata_d = ctrl_q & CTRL_STORED_MASK; // [R11] [R12]
                    ADDR_IRQ_STAT:  rdata_d = {{(DATA_W-IRQ_W){1'b0}}, stat_q};
                    ADDR_IRQ_MASK:  rdata_d = {{(DATA_W-IRQ_W){1'b0}}, mask_q};
                    default:        rdata_d = RD_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_q    <= RD_IDLE;
            pin_free_q <= 1'b0;
        end else begin
            rdata_q    <= rdata_d;
            pin_free_q <= pin_free_d;
        end
    end

    assign bus_rdata            = rdata_q;
    assign timer_output_pin     = pin_q;
    assign first_timer_clear    = clr1_q;
    assign second_timer_clear   = clr2_q;
    assign capture_one_event    = evt1_q;
    assign capture_two_event    = evt2_q;
    assign capture_one_flag     = stat_q[ST_CAP1];
    assign capture_two_pin_free = pin_free_q;
    assign first_timer_irq      = t1_irq_q;
    assign second_timer_irq     = t2_irq_q;
    assign irq                  = irq_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_force_high_pin: assert property ( // [R01]
        wr_cfg && bus_wdata[CFG_FORCE_HIGH] |=> timer_output_pin)
        else $error("timer output not high after force-high write");

    a_force_low_pin: assert property ( // [R02]
        wr_cfg && bus_wdata[CFG_FORCE_LOW] && !bus_wdata[CFG_FORCE_HIGH]
        |=> !timer_output_pin)
        else $error("timer output not low after force-low write");

    a_pin_holds_still: assert property ( // [R03]
        !(wr_cfg && (bus_wdata[CFG_FORCE_HIGH] || bus_wdata[CFG_FORCE_LOW]))
        |=> $stable(timer_output_pin))
        else $error("timer output moved without an override write");

    a_cfg_read_zero: assert property ( // [R03]
        rd_any && reg_hit(bus_addr, ADDR_CAP_CFG)
        |=> bus_rdata[DATA_W-1:CFG_FORCE_LOW] == '0)
        else $error("override or reserved bits read nonzero");

    a_tie_routes_input: assert property ( // [R04]
        ce && $past(ce) && tie_q && $past(tie_q) && sel1 == sel2
        |=> capture_one_event == capture_two_event)
        else $error("tied capture inputs disagree");

    a_second_fall_edge: assert property ( // [R05]
        ce && $past(ce) && !tie_q && $past(!tie_q) && sel2 == EDGE_FALL
        && $past(capture_input_two) && !capture_input_two
        |=> capture_two_event)
        else $error("falling edge on input two not captured");

    a_first_rise_edge: assert property ( // [R06]
        ce && $past(ce) && sel1 == EDGE_RISE && capture_input_one
        && !$past(capture_input_one) |=> capture_one_event)
        else $error("rising edge on input one not captured");

    a_first_both_quiet: assert property ( // [R06]
        ce && $past(ce) && sel1[1] && capture_input_one == $past(capture_input_one)
        |=> !capture_one_event)
        else $error("capture one event without an edge");

    a_second_irq_gate: assert property ( // [R07]
        !ctrl_q[CTRL_T2_IE] && $past(!ctrl_q[CTRL_T2_IE]) |-> !second_timer_irq)
        else $error("second timer interrupt while disabled");

    a_first_irq_gate: assert property ( // [R08]
        ce && ctrl_q[CTRL_T1_IE] && stat_q[ST_T1] |=> first_timer_irq)
        else $error("enabled first timer interrupt not raised");

    a_second_clear_pulse: assert property ( // [R09]
        wr_ctrl && bus_wdata[CTRL_T2_CLR] |=> second_timer_clear)
        else $error("second timer clear strobe missing");

    a_first_clear_pulse: assert property ( // [R10]
        wr_ctrl && bus_wdata[CTRL_T1_CLR] |=> first_timer_clear)
        else $error("first timer clear strobe missing");

    a_clear_idle_low: assert property ( // [R11]
        ce && !(wr_ctrl && bus_wdata[CTRL_T1_CLR]) && !(wr_ctrl && bus_wdata[CTRL_T2_CLR])
        |=> !first_timer_clear && !second_timer_clear)
        else $error("clear strobe without a one written");

    a_ctrl_read_zero: assert property ( // [R12]
        rd_any && reg_hit(bus_addr, ADDR_PAIR_CTRL)
        |=> (bus_rdata & ~CTRL_STORED_MASK) == '0)
        else $error("unused control bits read nonzero");

    a_flag_set_event: assert property ( // [R13]
        ce && capture_one_event |=> capture_one_flag)
        else $error("capture one flag not set by event");

    a_flag_stays_set: assert property ( // [R13]
        capture_one_flag && !(wr_stat && bus_wdata[ST_CAP1]) |=> capture_one_flag)
        else $error("capture one flag dropped without a clear");

endmodule : tcc_top

/* tcc_top_tb.sv */
// Self-checking testbench for the timer capture control block
`timescale 1ns/100ps
module tcc_top_tb;
    import tcc_pkg::*;

    logic              clk;
    logic              srst;
    logic              ce;
    logic [ADDR_W-1:0] bus_addr;
    logic [DATA_W-1:0] bus_wdata;
    logic              bus_wr;
    logic              bus_rd;
    logic [DATA_W-1:0] bus_rdata;
    logic              cin1;
    logic              cin2;
    logic              tev1;
    logic              tev2;
    logic              pin;
    logic              clr1;
    logic              clr2;
    logic              ev1;
    logic              ev2;
    logic              flag1;
    logic              pin_free;
    logic              tirq1;
    logic              tirq2;
    logic              irq;
    int                errors;
    int                num_checks;

    tcc_top dut_u (
        .clk                  (clk),
        .srst                 (srst),
        .ce                   (ce),
        .bus_addr             (bus_addr),
        .bus_wdata            (bus_wdata),
        .bus_wr               (bus_wr),
        .bus_rd               (bus_rd),
        .bus_rdata            (bus_rdata),
        .capture_input_one    (cin1),
        .capture_input_two    (cin2),
        .first_timer_event    (tev1),
        .second_timer_event   (tev2),
        .timer_output_pin     (pin),
        .first_timer_clear    (clr1),
        .second_timer_clear   (clr2),
        .capture_one_event    (ev1),
        .capture_two_event    (ev2),
        .capture_one_flag     (flag1),
        .capture_two_pin_free (pin_free),
        .first_timer_irq      (tirq1),
        .second_timer_irq     (tirq2),
        .irq                  (irq)
    );

    always #25 clk = ~clk;

    task automatic end_sim;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk_bit(input logic got, input logic exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : chk_bit

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk_byte

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cycles

    // Returns just after the taking edge, when the registered effects are visible
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        bus_wr    <= 1'b1;
        bus_addr  <= a;
        bus_wdata <= d;
        @(posedge clk);
        bus_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge clk);
        bus_rd   <= 1'b1;
        bus_addr <= a;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1;
        chk_byte(bus_rdata, exp, "read data");
    endtask : rd_chk

    // Counts high cycles of both capture pulses, so a stretched pulse shows as 2
    task automatic count_ev(output int n1, output int n2);
        n1 = 0;
        n2 = 0;
        repeat (5) begin
            @(posedge clk);
            #1;
            n1 += int'(ev1);
            n2 += int'(ev2);
        end
    endtask : count_ev

    task automatic t_reset;
        rd_chk(ADDR_CAP_CFG, 8'h00);
        rd_chk(ADDR_PAIR_CTRL, 8'h00);
        rd_chk(ADDR_IRQ_STAT, 8'h00);
        rd_chk(ADDR_IRQ_MASK, 8'h00);
        chk_bit(pin, 1'b0, "pin after reset");
    endtask : t_reset

    task automatic t_force;
        wr(ADDR_CAP_CFG, 8'h40);
        chk_bit(pin, 1'b1, "force high");
        rd_chk(ADDR_CAP_CFG, 8'h00);
        wr(ADDR_CAP_CFG, 8'h00);
        cycles(2);
        chk_bit(pin, 1'b1, "zero write moved pin");
        wr(ADDR_CAP_CFG, 8'h20);
        chk_bit(pin, 1'b0, "force low");
        rd_chk(ADDR_CAP_CFG, 8'h00);
        wr(ADDR_CAP_CFG, 8'h00);
        cycles(2);
        chk_bit(pin, 1'b0, "zero write moved pin");
        wr(ADDR_CAP_CFG, 8'h9f);
        rd_chk(ADDR_CAP_CFG, 8'h1f);
        wr(ADDR_CAP_CFG, 8'h00);
    endtask : t_force

    task automatic t_ctrl;
        wr(ADDR_PAIR_CTRL, 8'hff);
        chk_bit(clr1, 1'b1, "first clear");
        chk_bit(clr2, 1'b1, "second clear");
        cycles(1);
        chk_bit(clr1 | clr2, 1'b0, "clear not a pulse");
        rd_chk(ADDR_PAIR_CTRL, 8'h30);
        wr(ADDR_PAIR_CTRL, 8'h01);
        chk_bit(clr1, 1'b1, "first clear alone");
        chk_bit(clr2, 1'b0, "second clear on zero");
        wr(ADDR_PAIR_CTRL, 8'h02);
        chk_bit(clr1, 1'b0, "first clear on zero");
        chk_bit(clr2, 1'b1, "second clear alone");
        wr(ADDR_PAIR_CTRL, 8'h00);
        chk_bit(clr1 | clr2, 1'b0, "clear on zero write");
        rd_chk(ADDR_PAIR_CTRL, 8'h00);
        wr(4'h9, 8'hff);
        rd_chk(4'h9, 8'h00);
    endtask : t_ctrl

    task automatic t_edges;
        logic [1:0] s;
        logic       v;
        logic       e;
        int         n1;
        int         n2;
        for (int i = 0; i < 4; i++) begin
            s = 2'(i);
            wr(ADDR_CAP_CFG, {4'h0, s, s});
            for (int j = 0; j < 2; j++) begin
                v = (j == 0);
                e = v ? (s != 2'b00) : (s != 2'b01);
                @(posedge clk);
                cin1 <= v;
                cin2 <= v;
                count_ev(n1, n2);
                chk_byte(8'(n1), {7'h00, e}, "first capture count");
                chk_byte(8'(n2), {7'h00, e}, "second capture count");
            end
        end
    endtask : t_edges

    task automatic t_tie;
        int n1;
        int n2;
        wr(ADDR_CAP_CFG, 8'h14);
        cycles(2);
        chk_bit(pin_free, 1'b1, "pin free");
        @(posedge clk);
        cin2 <= 1'b1;
        count_ev(n1, n2);
        chk_byte(8'(n2), 8'h00, "own pin still captured");
        @(posedge clk);
        cin1 <= 1'b1;
        count_ev(n1, n2);
        chk_byte(8'(n2), 8'h01, "tied capture missing");
        @(posedge clk);
        cin1 <= 1'b0;
        cin2 <= 1'b0;
        wr(ADDR_CAP_CFG, 8'h00);
        cycles(2);
        chk_bit(pin_free, 1'b0, "pin not returned");
    endtask : t_tie

    task automatic t_irq;
        wr(ADDR_IRQ_STAT, 8'h0f);
        wr(ADDR_IRQ_MASK, 8'h01);
        wr(ADDR_CAP_CFG, 8'h01);
        cycles(2);
        chk_bit(flag1, 1'b0, "flag not cleared");
        @(posedge clk);
        cin1 <= 1'b1;
        cycles(8);
        chk_bit(flag1, 1'b1, "flag not sticky");
        chk_bit(irq, 1'b1, "masked irq");
        rd_chk(ADDR_IRQ_STAT, 8'h01);
        wr(ADDR_IRQ_STAT, 8'h01);
        cycles(2);
        chk_bit(flag1, 1'b0, "flag clear");
        chk_bit(irq, 1'b0, "irq clear");
        @(posedge clk);
        cin1 <= 1'b0;
        @(posedge clk);
        tev1 <= 1'b1;
        @(posedge clk);
        tev1 <= 1'b0;
        cycles(3);
        chk_bit(tirq1, 1'b0, "first irq while disabled");
        wr(ADDR_PAIR_CTRL, 8'h10);
        cycles(2);
        chk_bit(tirq1, 1'b1, "first irq enabled");
        chk_bit(tirq2, 1'b0, "second irq spurious");
        @(posedge clk);
        tev2 <= 1'b1;
        @(posedge clk);
        tev2 <= 1'b0;
        cycles(3);
        chk_bit(tirq2, 1'b0, "second irq while disabled");
        wr(ADDR_PAIR_CTRL, 8'h20);
        cycles(2);
        chk_bit(tirq2, 1'b1, "second irq enabled");
        chk_bit(tirq1, 1'b0, "first irq not gated");
    endtask : t_irq

    // A strobe while the enable is low must be ignored, and state must hold
    task automatic t_freeze;
        @(posedge clk);
        ce <= 1'b0;
        wr(ADDR_CAP_CFG, 8'h40);
        chk_bit(pin, 1'b0, "write taken while frozen");
        @(posedge clk);
        ce <= 1'b1;
        rd_chk(ADDR_CAP_CFG, 8'h01);
        chk_bit(pin, 1'b0, "pin moved after freeze");
    endtask : t_freeze

    // Whole run is under two hundred cycles; the 4000-cycle limit leaves a wide margin
    initial begin
        #(50 * 4000);
        errors++;
        end_sim();
    end

    initial begin
        clk        = 1'b0;
        srst       = 1'b1;
        ce         = 1'b1;
        bus_addr   = '0;
        bus_wdata  = '0;
        bus_wr     = 1'b0;
        bus_rd     = 1'b0;
        cin1       = 1'b0;
        cin2       = 1'b0;
        tev1       = 1'b0;
        tev2       = 1'b0;
        errors     = 0;
        num_checks = 0;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        cycles(1);
        t_reset();
        t_force();
        t_ctrl();
        t_edges();
        t_tie();
        t_irq();
        t_freeze();
        end_sim();
    end
endmodule : tcc_top_tb
